// ### src/opg_defs.svh
`ifndef OPG_DEFS_SVH
`define OPG_DEFS_SVH

// ----------------------------------------
// Timing, retry limit and identification address selects
// ----------------------------------------
`define OPG_CLK_NS 100
`define OPG_PW_NOM_NS 100000
`define OPG_PW_MIN_NS 95000
`define OPG_PW_MAX_NS 105000
`define OPG_PW_CYC (`OPG_PW_NOM_NS / `OPG_CLK_NS)
`define OPG_SETUP_NS 2000
`define OPG_SETUP_CYC ((`OPG_SETUP_NS + `OPG_CLK_NS - 1) / `OPG_CLK_NS)
`define OPG_TDF_NS 130
`define OPG_TDF_CYC ((`OPG_TDF_NS + `OPG_CLK_NS - 1) / `OPG_CLK_NS)
`define OPG_TDV_NS 1000
`define OPG_TDV_CYC ((`OPG_TDV_NS + `OPG_CLK_NS - 1) / `OPG_CLK_NS)
`define OPG_MAX_RETRY 10
`define OPG_ID_MFR_SEL 1'h0
`define OPG_ID_DEV_SEL 1'h1

`endif

// ### src/opg_pkg.sv
package opg_pkg;
  typedef enum logic [1:0] {OPG_CMD_PROG, OPG_CMD_READ_ID} opg_cmd_e;

  typedef struct packed {
    logic [15:0] addr;
    logic id_hv;
    logic ce_n;
    logic oe_vpp_low;
    logic oe_vpp_high;
    logic [7:0] dq_o;
    logic dq_oe;
  } opg_pins_s;

  typedef struct packed {
    logic done;
    logic pass;
    logic fail;
    logic [7:0] mfr_id;
    logic [7:0] dev_id;
  } opg_stat_s;
endpackage

// ### src/opg_timer.sv
`include "opg_defs.svh"

module opg_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control
  input wire logic start,
  input wire logic [W-1:0] cycles,
  // Status
  output logic expired
);
  logic [W-1:0] cnt_q;
  logic busy_q;
  wire cnt_last = busy_q && (cnt_q == {{(W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q <= cycles;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      busy_q <= !cnt_last;
    end
  end

  assign expired = cnt_last;
endmodule

// ### src/opg_programmer.sv
`include "opg_defs.svh"
module opg_programmer #(
  parameter int AW = 16,
  parameter int RETRIES = `OPG_MAX_RETRY,
  parameter int PW_CYC = `OPG_PW_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Command
  input wire logic start,
  input wire opg_pkg::opg_cmd_e cmd,
  input wire logic [AW-1:0] last_addr,
  // Source data lookup
  output logic [AW-1:0] src_addr,
  input wire logic [7:0] src_data,
  // Device pins
  output opg_pkg::opg_pins_s pins,
  input wire logic [7:0] dq_i,
  // Status
  output logic busy,
  output opg_pkg::opg_stat_s stat
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_PULSE, S_RECOV, S_VREAD, S_VSAMP, S_FINAL, S_FSAMP,
    S_IDRD, S_DONE, S_FLOAT
  } opg_st_e;
  typedef enum logic [1:0] {P_FIRST, P_VERIFY, P_FINAL, P_ID} opg_pass_e;
  opg_st_e st_q, st_d;
  opg_pass_e pass_q, pass_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [3:0] retry_q, retry_d;
  logic [1:0] idsel_q;
  logic fail_q, fail_d, done_q, busy_q, ok_q, bad_q;
  logic [7:0] mfr_q, dev_q;
  logic t_start;
  logic [15:0] t_cyc;
  logic t_exp;
  opg_pkg::opg_pins_s pins_q, pins_d;
  opg_timer #(.W(16)) u_tmr (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(t_start),
    .cycles(t_cyc),
    .expired(t_exp)
  );
  wire at_last = (addr_q == last_addr);
  wire match = (dq_i == src_data);
  wire retry_out = (retry_q == 4'(RETRIES));
  wire id_sel = idsel_q[0];
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    pass_d = pass_q;
    addr_d = addr_q;
    retry_d = retry_q;
    fail_d = fail_q;
    t_start = 1'b0;
    t_cyc = 16'(`OPG_SETUP_CYC);
    pins_d = pins_q;
    case (st_q)
      S_IDLE: begin
        if (start) begin
          addr_d = '0;
          retry_d = 4'h0;
          fail_d = 1'b0;
          t_start = 1'b1;
          pins_d.addr = '0;
          if (cmd == opg_pkg::OPG_CMD_READ_ID) begin
            pass_d = P_ID;
            pins_d.id_hv = 1'b1;
            pins_d.oe_vpp_low = 1'b1;
            st_d = S_IDRD;
            pins_d.ce_n = 1'b0;
            t_cyc = 16'(`OPG_TDV_CYC);
          end else begin
            pass_d = P_FIRST;
            pins_d.oe_vpp_high = 1'b1;
            pins_d.dq_oe = 1'b1;
            st_d = S_SETUP;
          end
        end
      end
      S_SETUP: begin
        pins_d.dq_o = src_data;
        if (t_exp) begin
          pins_d.ce_n = 1'b0;
          t_start = 1'b1;
          t_cyc = 16'(PW_CYC);
          st_d = S_PULSE;
        end
      end
      S_PULSE: if (t_exp) begin
        pins_d.ce_n = 1'b1;
        t_start = 1'b1;
        st_d = S_RECOV;
      end
      S_RECOV: if (t_exp) begin
        if (pass_q == P_FIRST) begin
          if (at_last) begin
            pass_d = P_VERIFY;
            addr_d = '0;
            pins_d.addr = '0;
            t_start = 1'b1;
            st_d = S_RECOV;
          end else begin
            addr_d = addr_q + 1'b1;
            pins_d.addr = addr_q + 1'b1;
            t_start = 1'b1;
            st_d = S_SETUP;
          end
        end else begin
          pins_d.dq_oe = 1'b0;
          pins_d.oe_vpp_high = 1'b0;
          pins_d.oe_vpp_low = 1'b1;
          pins_d.ce_n = 1'b0;
          t_start = 1'b1;
          t_cyc = 16'(`OPG_TDV_CYC);
          st_d = S_VSAMP;
        end
      end
      S_VSAMP: if (t_exp) begin
        pins_d.ce_n = 1'b1;
        pins_d.oe_vpp_low = 1'b0;
        t_start = 1'b1;
        if (match) begin
          retry_d = 4'h0;
          if (at_last) begin
            pass_d = P_FINAL;
            addr_d = '0;
            pins_d.addr = '0;
            st_d = S_FINAL;
          end else begin
            addr_d = addr_q + 1'b1;
            pins_d.addr = addr_q + 1'b1;
            st_d = S_VREAD;
          end
        end else if (retry_out) begin
          fail_d = 1'b1;
          st_d = S_DONE;
        end else begin
          retry_d = retry_q + 4'h1;
          t_cyc = 16'(`OPG_TDF_CYC);
          st_d = S_FLOAT;
        end
      end
      S_FLOAT: if (t_exp) begin
        pins_d.oe_vpp_high = 1'b1;
        pins_d.dq_oe = 1'b1;
        t_start = 1'b1;
        st_d = S_SETUP;
      end
      S_VREAD: if (t_exp) begin
        pins_d.oe_vpp_low = 1'b1;
        pins_d.ce_n = 1'b0;
        t_start = 1'b1;
        t_cyc = 16'(`OPG_TDV_CYC);
        st_d = S_VSAMP;
      end
      S_FINAL: if (t_exp) begin
        pins_d.oe_vpp_low = 1'b1;
        pins_d.ce_n = 1'b0;
        t_start = 1'b1;
        t_cyc = 16'(`OPG_TDV_CYC);
        st_d = S_FSAMP;
      end
      S_FSAMP: if (t_exp) begin
        if (!match) fail_d = 1'b1;
        t_start = 1'b1;
        t_cyc = 16'(`OPG_TDF_CYC);
        pins_d.ce_n = 1'b1;
        pins_d.oe_vpp_low = 1'b0;
        if (at_last) begin
          st_d = S_DONE;
        end else begin
          addr_d = addr_q + 1'b1;
          pins_d.addr = addr_q + 1'b1;
          st_d = S_FINAL;
        end
      end
      S_IDRD: if (t_exp) begin
        t_start = 1'b1;
        t_cyc = 16'(`OPG_TDV_CYC);
        if (id_sel == `OPG_ID_DEV_SEL) begin
          pins_d = '0;
          pins_d.ce_n = 1'b1;
          st_d = S_DONE;
        end else begin
          pins_d.addr = {{(AW-1){1'b0}}, `OPG_ID_DEV_SEL};
        end
      end
      S_DONE: begin
        pins_d = '0;
        pins_d.ce_n = 1'b1;
        pins_d.addr = addr_q;
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      pass_q <= P_FIRST;
      addr_q <= '0;
      retry_q <= 4'h0;
      fail_q <= 1'b0;
      pins_q <= '{ce_n: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
      pass_q <= pass_d;
      addr_q <= addr_d;
      retry_q <= retry_d;
      fail_q <= fail_d;
      pins_q <= pins_d;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idsel_q <= 2'h0;
      mfr_q <= 8'h00;
      dev_q <= 8'h00;
      done_q <= 1'b0;
      ok_q <= 1'b0;
      bad_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      done_q <= (st_q == S_DONE);
      ok_q <= (st_q == S_DONE) && !fail_q;
      bad_q <= (st_q == S_DONE) && fail_q;
      busy_q <= (st_d != S_IDLE);
      if (st_q == S_IDLE) idsel_q <= 2'h0;
      if (st_q == S_IDRD && t_exp) begin
        idsel_q <= idsel_q + 2'h1;
        if (id_sel == `OPG_ID_MFR_SEL) mfr_q <= dq_i;
        else dev_q <= dq_i;
      end
    end
  end
  assign pins = pins_q;
  assign busy = busy_q;
  assign src_addr = addr_q;
  assign stat = '{done: done_q, pass: ok_q, fail: bad_q, mfr_id: mfr_q, dev_id: dev_q};
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  int unsigned pw_cnt;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) pw_cnt <= 0;
    else if (st_q == S_PULSE) pw_cnt <= pw_cnt + 1;
    else pw_cnt <= 0;
  end
  a_pulse_width: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == S_PULSE && st_d != S_PULSE) |-> (pw_cnt + 1 >= 950 && pw_cnt + 1 <= 1050))
    else $error("program pulse width out of range");
  a_retry_limit: assert property (@(posedge clk_sys) disable iff (!rstn)
    retry_q <= 4'(RETRIES)) else $error("too many retries");
  a_fail_abort: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == S_VSAMP && t_exp && !match && retry_out) |=> (st_q == S_DONE && fail_q))
    else $error("failed byte did not abort");
  a_start_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == S_IDLE && start) |=> (pins.addr == '0))
    else $error("sequence not started at address zero");
  a_no_drive_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    pins.oe_vpp_low |-> !pins.dq_oe) else $error("data driven during read");
  a_id_pins: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == S_IDRD) |-> (pins.id_hv && pins.addr[AW-1:1] == '0))
    else $error("identification address not held low");
  a_step_on_match: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == S_VSAMP && t_exp && match && !at_last) |=> (addr_q == $past(addr_q) + 1'b1))
    else $error("address did not step after verify");
  a_final_fail: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == S_FSAMP && t_exp && !match) |=> fail_q) else $error("final mismatch lost");
  c_prog_pass: cover property (@(posedge clk_sys) disable iff (!rstn) stat.pass);
  c_prog_fail: cover property (@(posedge clk_sys) disable iff (!rstn) stat.fail);
  c_retry: cover property (@(posedge clk_sys) disable iff (!rstn) retry_q == 4'h2);
  c_id_read: cover property (@(posedge clk_sys) disable iff (!rstn) st_q == S_IDRD && id_sel);
endmodule

// ### bench/opg_otp_model.sv
// ----------------------------------------
// Behavioural memory device on the pins
// ----------------------------------------
module opg_otp_model #(
  parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC3 // arbitrary value
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic [7:0] need,
  // Pins
  input wire opg_pkg::opg_pins_s pins,
  output logic [7:0] dq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:3];
  logic [7:0] cnt [0:3];
  logic [7:0] last_q = 8'h00;
  logic rd;
  logic [7:0] val;
  // Read, verify and identification drive the outputs
  assign rd = !pins.ce_n && pins.oe_vpp_low;
  assign val = pins.id_hv ? (pins.addr[0] ? DEV_CODE : MFR_CODE) : mem[pins.addr[1:0]];
  // Released lines show the inverse of the last value
  assign dq = rd ? val : ~last_q;
  always @(posedge clk_sys) begin
    if (rd) begin
      last_q <= val;
    end
  end
  // Clear, then a byte takes after a number of pulses
  always @(posedge clr or posedge pins.ce_n) begin
    if (clr) begin
      for (int i = 0; i < 4; i++) begin
        mem[i] = 8'hFF;
        cnt[i] = 8'h00;
      end
    end else if (pins.oe_vpp_high && pins.dq_oe) begin
      cnt[pins.addr[1:0]] = cnt[pins.addr[1:0]] + 8'h01;
      if (cnt[pins.addr[1:0]] >= need) begin
        mem[pins.addr[1:0]] = pins.dq_o;
      end
    end
  end
endmodule

// ### bench/test_otp_byte_program_and_id_readout.sv
`include "opg_defs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: value mismatch", $time); end end

module test_otp_byte_program_and_id_readout;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  opg_pkg::opg_cmd_e cmd = opg_pkg::OPG_CMD_READ_ID;
  logic [15:0] last_addr = 16'h0000;
  logic [15:0] src_addr;
  logic [7:0] src [0:3];
  logic [7:0] dq_i;
  logic busy;
  opg_pkg::opg_pins_s pins;
  opg_pkg::opg_stat_s stat;
  logic clr = 1'b0;
  logic [7:0] need = 8'h01;
  logic [25:0] exp_q [$];
  logic [25:0] e;
  logic [7:0] npulse = 8'h00;
  int pw = 0;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  logic ce_d = 1'b1;

  always #50 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Design and device
  // ----------------------------------------
  opg_programmer dut (
    .clk_sys(clk_sys), .rstn(rstn), .start(start), .cmd(cmd), .last_addr(last_addr),
    .src_addr(src_addr), .src_data(src[src_addr[1:0]]), .pins(pins), .dq_i(dq_i),
    .busy(busy), .stat(stat)
  );
  opg_otp_model dev (.clk_sys(clk_sys), .clr(clr), .need(need), .pins(pins), .dq(dq_i));

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Monitor of pins and results
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      test_done();
    end
  end

  always @(posedge clk_sys) begin
    ce_d <= pins.ce_n;
    if (pins.oe_vpp_high && !pins.ce_n) begin
      pw <= pw + 1;
    end
    if (pins.oe_vpp_high && ce_d && !pins.ce_n) begin
      npulse <= npulse + 8'h01;
      pw <= 1;
      if (npulse == 8'h00) `CHK(pins.addr, 16'h0000)
      `CHK(pins.dq_o, src[pins.addr[1:0]])
      `CHK(src_addr, pins.addr)
    end
    if (pins.oe_vpp_high && !ce_d && pins.ce_n) begin
      `CHK(pw, `OPG_PW_CYC)
    end
    if (pins.id_hv && !pins.ce_n) begin
      `CHK(pins.addr[15:1], 15'h0000)
    end
    if (stat.done === 1'b1) begin
      e = exp_q.pop_front();
      `CHK({stat.pass, stat.fail}, e[25:24])
      `CHK(npulse, e[23:16])
      `CHK({stat.mfr_id, stat.dev_id}, e[15:0])
      `CHK(busy, 1'b0)
      npulse <= 8'h00;
    end
  end

  // ----------------------------------------
  // Commands
  // ----------------------------------------
  task automatic run(input opg_pkg::opg_cmd_e c, input logic [7:0] nd, input logic [25:0] x);
    @(posedge clk_sys);
    clr <= 1'b1;
    need <= nd;
    @(posedge clk_sys);
    clr <= 1'b0;
    start <= 1'b1;
    cmd <= c;
    last_addr <= 16'h0001;
    exp_q.push_back(x);
    @(posedge clk_sys);
    start <= 1'b0;
    @(posedge clk_sys);
    while (busy !== 1'b0) begin
      @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask

  initial begin
    void'($urandom(98677));
    for (int i = 0; i < 4; i++) begin
      src[i] = 8'(($urandom() & 32'hFE));
    end
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    // Identification bytes by address bit 0
    run(opg_pkg::OPG_CMD_READ_ID, 8'h01, {2'b10, 8'h00, 8'h5A, 8'hC3});
    // Both bytes take on the first pass
    run(opg_pkg::OPG_CMD_PROG, 8'h01, {2'b10, 8'h02, 8'h5A, 8'hC3});
    // Each byte needs two retries
    run(opg_pkg::OPG_CMD_PROG, 8'h03, {2'b10, 8'h06, 8'h5A, 8'hC3});
    // Byte never takes: ten retries then fail
    run(opg_pkg::OPG_CMD_PROG, 8'h63, {2'b01, 8'h0C, 8'h5A, 8'hC3});
    `CHK(exp_q.size(), 0)
    test_done();
  end
endmodule
